// >>> rtl/tws_slave_tx.sv
// Two-wire slave transmitter with AHB-Lite register access
`timescale 1ns/1ps
module tws_slave_tx (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Two-wire pins, open drain
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   // Neighbouring logic
   input  wire logic        arb_lost,
   input  wire logic        deep_sleep,
   output logic             wake_req,
   output logic             start_go,
   output logic             rx_addressed
);
   // -------------------------------------------------
   // Declarations
   // -------------------------------------------------
   logic [7:0]  oar_q;          // own_slave_address
   logic        flag_q;         // interrupt_flag
   logic        ack_en_q;       // acknowledge_enable
   logic        sta_q;          // start_request
   logic        sto_q;          // stop_request
   logic        wc_q;           // write_collision_flag
   logic        en_q;           // interface_enable
   logic        ie_q;           // interrupt_enable
   logic [1:0]  presc_q;        // Prescaler bits, stored only
   logic [7:0]  data_q;         // serial_data_register
   logic [7:0]  code_q;         // Status code while flagged
   logic        wr_q;           // Data phase is a write
   logic [7:0]  waddr_q;        // Data phase address
   logic        scl_s1, scl_s2, scl_s3;  // Clock synchroniser
   logic        sda_s1, sda_s2, sda_s3;  // Data synchroniser
   tws_pkg::tws_state_t state_q;         // Link state
   logic [3:0]  cnt_q;          // Clock rises in this byte
   logic [7:0]  sh_q;           // Address or data shifter
   logic        last_q;         // Byte in flight is the last
   logic        mack_q;         // Master acknowledged
   logic        hit_q;          // Address matched, read
   logic        busy_q;         // Bus between start and stop
   logic        pend_q;         // Start waiting for free bus
   logic        wake_q;         // Woke from deep sleep
   logic        sda_oe_q, scl_oe_q, start_go_q, rxa_q;
   logic [31:0] hrdata_q;
   logic        may_ack_wr_q;   // Own or general call address matched, write
   // -------------------------------------------------
   // Pin conditioning
   // -------------------------------------------------
   // Two stages before use; third stage only for edge finding
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {scl_s1, scl_s2, scl_s3} <= 3'h7;
         {sda_s1, sda_s2, sda_s3} <= 3'h7;
      end else begin
         {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
      end
   end
   wire scl_rise = scl_s2 & ~scl_s3;            // Bus clock rising
   wire scl_fall = ~scl_s2 & scl_s3;            // Bus clock falling
   wire bus_start = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;  // Start seen
   wire bus_stop  = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;  // Stop seen
   // -------------------------------------------------
   // Bus slave decode
   // -------------------------------------------------
   wire       ahb_go   = hsel & htrans[1] & hready;      // Transfer taken
   wire       ahb_wr   = ahb_go & hwrite;
   wire       wr_ctrl  = wr_q & (waddr_q == tws_pkg::OFS_CTRL);
   wire       wr_addr  = wr_q & (waddr_q == tws_pkg::OFS_ADDR);
   wire       wr_stat  = wr_q & (waddr_q == tws_pkg::OFS_STAT);
   wire       wr_data  = wr_q & (waddr_q == tws_pkg::OFS_DATA);
   wire       flag_clr = wr_ctrl & hwdata[tws_pkg::CTRL_FLAG];  // Write one clears
   wire [7:0] ctrl_rd  = {flag_q, ack_en_q, sta_q, sto_q, wc_q, en_q, 1'b0, ie_q};
   wire [7:0] stat_rd  = {(flag_q ? code_q[7:3] : tws_pkg::SC_NONE[7:3]), 1'b0, presc_q}; // [R20] [R19]
   wire [7:0] rd_byte  = (haddr == tws_pkg::OFS_ADDR) ? oar_q :
                         (haddr == tws_pkg::OFS_CTRL) ? ctrl_rd :
                         (haddr == tws_pkg::OFS_STAT) ? stat_rd :
                         (haddr == tws_pkg::OFS_DATA) ? data_q : 8'h00;
   // -------------------------------------------------
   // Address match and event decode
   // -------------------------------------------------
   wire [7:0] addr_byte = {sh_q[6:0], sda_s2};                  // Byte after 8th rise
   wire own_hit = addr_byte[7:1] == oar_q[7:1];                 // [R1]
   wire gc_hit  = (addr_byte[7:1] == tws_pkg::GC_ADDR[7:1]) & oar_q[tws_pkg::ADDR_GCE]; // [R2]
   wire may_ack = en_q & ack_en_q & (own_hit | gc_hit);        // [R15] [R16]
   wire addr_done = (state_q == tws_pkg::LS_ADDR) & scl_fall & (cnt_q == tws_pkg::BITS_BYTE);
   wire aack_done = (state_q == tws_pkg::LS_AACK) & scl_fall & (cnt_q == tws_pkg::BITS_ACK);
   wire tack_done = (state_q == tws_pkg::LS_TACK) & scl_fall & (cnt_q == tws_pkg::BITS_ACK);
   wire flag_set  = aack_done | tack_done;
   wire resume    = (state_q == tws_pkg::LS_WAIT) & ~flag_q;    // Software answered
   wire in_ending = (code_q == tws_pkg::SC_DAT_NAK) | (code_q == tws_pkg::SC_LST_ACK);
   // Code reported at the end of a byte
   wire [7:0] next_code = aack_done ? (arb_lost ? tws_pkg::SC_ARB_RD : tws_pkg::SC_OWN_RD) : // [R5] [R6]
                          ~mack_q ? tws_pkg::SC_DAT_NAK :                                 // [R9]
                          last_q  ? tws_pkg::SC_LST_ACK : tws_pkg::SC_DAT_ACK;           // [R10] [R7]
   // -------------------------------------------------
   // Register writes
   // -------------------------------------------------
   // Capture the address phase; the slave never waits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q     <= 1'b0;
         waddr_q  <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end else begin
         wr_q     <= ahb_wr;
         waddr_q  <= haddr;
         hrdata_q <= (ahb_go & ~hwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end
   // Control fields stored from software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oar_q    <= tws_pkg::RST_ADDR;
         ack_en_q <= 1'b0;
         sta_q    <= 1'b0;
         sto_q    <= 1'b0;
         en_q     <= 1'b0;
         ie_q     <= 1'b0;
         presc_q  <= 2'h0;
      end else begin
         if (wr_addr) begin
            oar_q <= hwdata[7:0];
         end
         if (wr_stat) begin
            presc_q <= hwdata[1:0];
         end
         if (wr_ctrl) begin
            ack_en_q <= hwdata[tws_pkg::CTRL_ACK];
            sta_q    <= hwdata[tws_pkg::CTRL_STA];
            sto_q    <= hwdata[tws_pkg::CTRL_STO];
            en_q     <= hwdata[tws_pkg::CTRL_EN];
            ie_q     <= hwdata[tws_pkg::CTRL_IE];
         end
      end
   end
   // Flag: a set in the same cycle as a clear wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_q <= 1'b0;
         code_q <= tws_pkg::SC_NONE;
      end else if (flag_set) begin
         flag_q <= 1'b1;
         code_q <= next_code;                                // [R21]
      end else if (flag_clr) begin
         flag_q <= 1'b0;
      end
   end
   // Data register: loaded only while flagged, else collision
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_q <= tws_pkg::RST_DATA;
         wc_q   <= 1'b0;
      end else if (wr_data) begin
         if (flag_q) begin
            data_q <= hwdata[7:0];                   // Never loaded from the bus [R18]
            wc_q   <= 1'b0;
         end else begin
            wc_q <= 1'b1;
         end
      end
   end
   // -------------------------------------------------
   // Link state machine
   // -------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q  <= tws_pkg::LS_IDLE;
         cnt_q    <= 4'h0;
         sh_q     <= 8'h00;
         last_q   <= 1'b0;
         mack_q   <= 1'b0;
         hit_q    <= 1'b0;
         sda_oe_q <= 1'b0;
         scl_oe_q <= 1'b0;
      end else if (bus_start & (state_q != tws_pkg::LS_WAIT)) begin
         state_q  <= tws_pkg::LS_ADDR;
         cnt_q    <= 4'h0;
         sda_oe_q <= 1'b0;
      end else if (bus_stop & (state_q != tws_pkg::LS_WAIT)) begin
         state_q  <= tws_pkg::LS_IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         case (state_q)
            tws_pkg::LS_ADDR: begin
               if (scl_rise) begin
                  sh_q  <= addr_byte;
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == 4'h7) begin
                     hit_q <= may_ack & sda_s2;
                  end
               end else if (addr_done) begin
                  if (hit_q) begin
                     state_q  <= tws_pkg::LS_AACK;     // [R4]
                     sda_oe_q <= 1'b1;
                  end else begin
                     state_q <= tws_pkg::LS_IGN;       // [R15]
                  end
               end
            end
            tws_pkg::LS_AACK, tws_pkg::LS_TACK: begin
               if (scl_rise) begin
                  cnt_q  <= cnt_q + 4'h1;
                  mack_q <= ~sda_s2;
               end else if (flag_set) begin
                  state_q  <= tws_pkg::LS_WAIT;
                  sda_oe_q <= 1'b0;
                  scl_oe_q <= 1'b1;                    // [R21]
               end
            end
            tws_pkg::LS_WAIT: begin
               if (resume & in_ending) begin
                  state_q  <= tws_pkg::LS_IGN;         // [R11] [R12] [R14]
                  scl_oe_q <= 1'b0;
               end else if (resume) begin
                  state_q  <= tws_pkg::LS_TX;
                  sh_q     <= data_q;
                  last_q   <= ~ack_en_q;               // [R8]
                  cnt_q    <= 4'h0;
                  sda_oe_q <= ~data_q[7];
                  scl_oe_q <= 1'b0;
               end
            end
            tws_pkg::LS_TX: begin
               if (scl_rise) begin
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall & (cnt_q == tws_pkg::BITS_BYTE)) begin
                  state_q  <= tws_pkg::LS_TACK;
                  sda_oe_q <= 1'b0;
               end else if (scl_fall) begin
                  sh_q     <= {sh_q[6:0], 1'b1};
                  sda_oe_q <= ~sh_q[6];
               end
            end
            tws_pkg::LS_IDLE, tws_pkg::LS_IGN: begin
               sda_oe_q <= 1'b0;                       // [R14]
            end
            default: begin
               state_q  <= tws_pkg::LS_IDLE;
               sda_oe_q <= 1'b0;
               scl_oe_q <= 1'b0;
            end
         endcase
      end
   end
   // -------------------------------------------------
   // Bus occupancy, queued start, wake and receiver entry
   // -------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_q     <= 1'b0;
         pend_q     <= 1'b0;
         start_go_q <= 1'b0;
         wake_q     <= 1'b0;
         rxa_q      <= 1'b0;
      end else begin
         busy_q <= bus_start | (busy_q & ~bus_stop);
         // Start issued once the bus is free
         start_go_q <= pend_q & ~busy_q & ~start_go_q;          // [R13]
         if (resume & in_ending & sta_q) begin
            pend_q <= 1'b1;                                      // [R13]
         end else if (start_go_q) begin
            pend_q <= 1'b0;
         end
         // Wake held until software clears the flag
         if (aack_done & deep_sleep) begin
            wake_q <= 1'b1;                                      // [R16] [R17]
         end else if (resume) begin
            wake_q <= 1'b0;
         end
         // Write direction hands over to the receiver half
         if (addr_done & ~hit_q & may_ack_wr_q) begin
            rxa_q <= 1'b1;                                       // [R4]
         end else if (bus_stop | bus_start) begin
            rxa_q <= 1'b0;
         end
      end
   end
   // Own or general call address matched with the write bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         may_ack_wr_q <= 1'b0;
      end else if ((state_q == tws_pkg::LS_ADDR) & scl_rise & (cnt_q == 4'h7)) begin
         may_ack_wr_q <= may_ack & ~sda_s2;
      end
   end
   // -------------------------------------------------
   // Outputs
   // -------------------------------------------------
   assign hrdata       = hrdata_q;
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign scl_o        = 1'b0;
   assign sda_o        = 1'b0;
   assign scl_oe       = scl_oe_q;
   assign sda_oe       = sda_oe_q;
   assign wake_req     = wake_q;
   assign start_go     = start_go_q;
   assign rx_addressed = rxa_q;
   // -------------------------------------------------
   // Assertions
   // -------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   no_info_code_a: assert property (!flag_q |-> stat_rd[7:3] == tws_pkg::SC_NONE[7:3])
      else $error("status not idle code with flag clear"); // [R20]
   code_stable_a: assert property (flag_q && $past(flag_q) && !$past(flag_set) |-> $stable(code_q))
      else $error("status changed while flagged"); // [R21]
   clock_hold_a: assert property (state_q == tws_pkg::LS_WAIT && flag_q |-> scl_oe_q)
      else $error("clock released while flagged"); // [R17]
   addr_read_a: assert property (aack_done && !arb_lost |=> flag_q && code_q == tws_pkg::SC_OWN_RD)
      else $error("own read address did not give a8"); // [R5]
   arb_read_a: assert property (aack_done && arb_lost |=> flag_q && code_q == tws_pkg::SC_ARB_RD)
      else $error("arbitration read did not give b0"); // [R6]
   data_ack_a: assert property (tack_done && mack_q && !last_q |=> code_q == tws_pkg::SC_DAT_ACK)
      else $error("acked byte did not give b8"); // [R7]
   data_nak_a: assert property (tack_done && !mack_q |=> code_q == tws_pkg::SC_DAT_NAK)
      else $error("nacked byte did not give c0"); // [R9]
   last_ack_a: assert property (tack_done && mack_q && last_q |=> code_q == tws_pkg::SC_LST_ACK)
      else $error("acked last byte did not give c8"); // [R10]
   ack_off_a: assert property (addr_done && !$past(ack_en_q, 2) && !ack_en_q |=> state_q != tws_pkg::LS_AACK)
      else $error("address acked with ack disabled"); // [R15]
   ignore_ones_a: assert property (state_q == tws_pkg::LS_IGN |=> !sda_oe_q)
      else $error("data driven while not addressed"); // [R14]
   last_mark_a: assert property (resume && !in_ending |=> last_q == !$past(ack_en_q))
      else $error("last byte mark wrong"); // [R8]
endmodule

// >>> inc/tws_pkg.sv
// Constants for the two-wire slave transmitter block
// What this block does
// (R1) Answer own 7-bit address from upper bits
// (R2) Address bit 0 enables general call 0x00
// (R3) Software sets enable and ack, clears start/stop
// (R4) Read bit selects transmitter, else receiver
// (R5) Own address plus read acked gives 0xA8
// (R6) Lost arbitration then addressed gives 0xB0
// (R7) Byte sent and acked gives 0xB8
// (R8) Ack-enable zero marks next byte as last
// (R9) Byte sent and not acked gives 0xC0
// (R10) Last byte sent yet acked gives 0xC8
// (R11) Clear with ack-enable zero stops recognition
// (R12) Clear with ack-enable one keeps recognition
// (R13) Start request queues start when bus free
// (R14) After last byte master reads all ones
// (R15) Ack-enable zero isolates, setting it resumes
// (R16) Deep sleep still acks address and wakes
// (R17) After wake hold clock low until cleared
// (R18) Data register need not hold bus byte
// (R19) Software masks prescaler bits before comparing
// (R20) Flag clear reports status 0xF8
// (R21) Status stable and clock stretched while flagged
package tws_pkg;
   // -------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------
   localparam logic [7:0] OFS_ADDR = 8'h00;  // own_slave_address
   localparam logic [7:0] OFS_CTRL = 8'h04;  // serial_control
   localparam logic [7:0] OFS_STAT = 8'h08;  // serial_status
   localparam logic [7:0] OFS_DATA = 8'h0c;  // serial_data_register
   // -------------------------------------------------
   // serial_control and own_slave_address bit positions
   // -------------------------------------------------
   localparam int CTRL_FLAG = 7;  // interrupt_flag
   localparam int CTRL_ACK  = 6;  // acknowledge_enable
   localparam int CTRL_STA  = 5;  // start_request
   localparam int CTRL_STO  = 4;  // stop_request
   localparam int CTRL_WC   = 3;  // write_collision_flag
   localparam int CTRL_EN   = 2;  // interface_enable
   localparam int CTRL_IE   = 0;  // interrupt_enable
   localparam int ADDR_GCE  = 0;  // general_call_enable
   // -------------------------------------------------
   // Reset values
   // -------------------------------------------------
   localparam logic [7:0] RST_ADDR = 8'hfe;
   localparam logic [7:0] RST_DATA = 8'hff;
   // -------------------------------------------------
   // Status codes, general call address and bit counts
   // -------------------------------------------------
   localparam logic [7:0] SC_OWN_RD  = 8'ha8;
   localparam logic [7:0] SC_ARB_RD  = 8'hb0;
   localparam logic [7:0] SC_DAT_ACK = 8'hb8;
   localparam logic [7:0] SC_DAT_NAK = 8'hc0;
   localparam logic [7:0] SC_LST_ACK = 8'hc8;
   localparam logic [7:0] SC_NONE    = 8'hf8;
   localparam logic [7:0] GC_ADDR    = 8'h00;
   localparam logic [3:0] BITS_BYTE  = 4'h8;
   localparam logic [3:0] BITS_ACK   = 4'h9;
   // -------------------------------------------------
   // Link state machine
   // -------------------------------------------------
   typedef enum logic [2:0] {
      LS_IDLE = 3'b000,  // Bus free or not yet started
      LS_ADDR = 3'b001,  // Shifting in address byte
      LS_AACK = 3'b010,  // Driving address acknowledge
      LS_TX   = 3'b011,  // Shifting out data byte
      LS_TACK = 3'b100,  // Sampling master acknowledge
      LS_WAIT = 3'b101,  // Flag set, clock stretched
      LS_IGN  = 3'b110   // Not addressed until start/stop
   } tws_state_t;
endpackage

// >>> bench/tws_master_model.sv
// Behavioural two-wire bus master receiver for the bench
`timescale 1ns/1ps
module tws_master_model (
   // Wire levels after the pull-ups
   input  wire logic scl,
   input  wire logic sda,
   // Open-drain pulls, high pulls the wire low
   output logic      scl_low,
   output logic      sda_low
);
   localparam time HALF = 40ns;  // Half of the 80 ns link clock

   // Both lines released at time zero
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end

   // One bit: set data while low, wait out stretching, sample mid-high
   task automatic bit_io(input logic b, output logic s);
      #10ns;
      sda_low = ~b;
      #(HALF - 10ns);
      scl_low = 1'b0;
      wait (scl === 1'b1);
      #(HALF / 2);
      s = sda;
      #(HALF / 2);
      scl_low = 1'b1;
   endtask

   // Start or repeated start: data falls while clock high
   task automatic start_cond();
      sda_low = 1'b0;
      scl_low = 1'b0;
      wait (scl === 1'b1);
      #HALF;
      sda_low = 1'b1;
      #HALF;
      scl_low = 1'b1;
   endtask

   // Stop: data rises while clock high, clock then stands still
   task automatic stop_cond();
      #10ns;
      sda_low = 1'b1;
      #HALF;
      scl_low = 1'b0;
      wait (scl === 1'b1);
      #HALF;
      sda_low = 1'b0;
      #HALF;
   endtask

   // Address byte out, most significant bit first; ack is a low ninth bit
   task automatic put_byte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(v[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask

   // Data byte in, then the master's ack or nack
   task automatic get_byte(input logic ack, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, v[i]);
      end
      bit_io(~ack, s);
   endtask
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the two-wire slave transmitter
`timescale 1ns/1ps
module tb_top;
   // Bus and control stimulus
   logic        hclk, hresetn, hsel, hwrite, arb_lost, deep_sleep, go_seen;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata;
   // Design outputs and wire levels
   logic        hreadyout, scl_oe, sda_oe, wake_req, start_go, m_scl, m_sda, rx_addr;
   wire         scl_w = ~(m_scl | scl_oe);
   wire         sda_w = ~(m_sda | sda_oe);
   // Bench model state
   logic [7:0]  byte_q[$];
   int          num_errors, total_checks;

   tws_slave_tx dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe), .sda_i(sda_w),
      .sda_o(), .sda_oe(sda_oe), .arb_lost(arb_lost), .deep_sleep(deep_sleep), .wake_req(wake_req),
      .start_go(start_go), .rx_addressed(rx_addr));
   tws_master_model pm_u (.scl(scl_w), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda));

   // 100 MHz clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // Remember any queued-start pulse
   always @(posedge hclk) begin
      if (start_go === 1'b1) go_seen <= 1'b1;
   end

   // Comparison of any result
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   // One single AHB-Lite word transfer
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   // Control word: clear flag, enable, chosen ack and start request
   function automatic logic [31:0] ctl(input logic a, input logic s);
      return {24'h0, 1'b1, a, s, 2'b00, 1'b1, 2'b00};
   endfunction

   // Poll the flag under a bound, then compare the masked status
   task automatic wait_flag(input logic [7:0] code);
      logic [31:0] r;
      int          n;
      n = 0;
      do begin
         xfer(1'b0, tws_pkg::OFS_CTRL, 32'h0, r);
         n++;
      end while (r[7] !== 1'b1 && n < 100);
      xfer(1'b0, tws_pkg::OFS_STAT, 32'h0, r);
      chk("status", {24'h0, code}, r & 32'hf8);
   endtask

   // Load a random byte, note it in the model, clear the flag
   task automatic load(input logic a);
      logic [31:0] r;
      logic [7:0]  d;
      d = 8'($urandom);
      xfer(1'b1, tws_pkg::OFS_DATA, {24'h0, d}, r);
      byte_q.push_back(d);
      xfer(1'b1, tws_pkg::OFS_CTRL, ctl(a, 1'b0), r);
   endtask

   // Master reads one byte; model predicts it
   task automatic mread(input logic ack);
      logic [7:0] v;
      pm_u.get_byte(ack, v);
      chk("tx byte", {24'h0, byte_q.pop_front()}, {24'h0, v});
   endtask

   // Start plus address with read bit; compare the acknowledge
   task automatic addr_rd(input logic [6:0] a, input logic e);
      logic ack;
      pm_u.start_cond();
      pm_u.put_byte({a, 1'b1}, ack);
      chk("addr ack", {31'h0, e}, {31'h0, ack});
   endtask

   // Verdict and end of run
   task automatic summarize();
      if (num_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Watchdog against a hung handshake or link
   initial begin
      #400us;
      num_errors++;
      summarize();
   end

   // Main sequence
   initial begin
      logic [31:0] r;
      logic [7:0]  v;
      logic        ack;
      {hresetn, hsel, hwrite, arb_lost, deep_sleep, go_seen} = '0;
      {haddr, htrans, hwdata} = '0;
      hsize = 3'b010;
      num_errors = 0;
      total_checks = 0;
      void'($urandom(31));
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(1'b0, tws_pkg::OFS_STAT, 32'h0, r);
      chk("idle status", 32'hf8, r);
      xfer(1'b0, 8'h10, 32'h0, r);
      chk("unmapped", 32'h0, r);
      // Data write with the flag clear is refused and flagged
      xfer(1'b1, tws_pkg::OFS_DATA, 32'h5a, r);
      xfer(1'b0, tws_pkg::OFS_CTRL, 32'h0, r);
      chk("collision", 32'h08, r);
      xfer(1'b0, tws_pkg::OFS_DATA, 32'h0, r);
      chk("data kept", 32'hff, r);
      // Prescaler bits set, so status compares must mask them
      xfer(1'b1, tws_pkg::OFS_STAT, 32'h3, r);
      xfer(1'b1, tws_pkg::OFS_ADDR, 32'h6a, r);
      xfer(1'b1, tws_pkg::OFS_CTRL, 32'h44, r);
      addr_rd(7'h36, 1'b0);
      pm_u.stop_cond();
      // Own address with write bit goes to the receiver half
      pm_u.start_cond();
      pm_u.put_byte(8'h6a, ack);
      chk("write ack", 32'h0, {31'h0, ack});
      chk("rx addressed", 32'h1, {31'h0, rx_addr});
      pm_u.stop_cond();
      // An acked byte, then a last byte that the master still acks
      addr_rd(7'h35, 1'b1);
      wait_flag(tws_pkg::SC_OWN_RD);
      load(1'b1);
      mread(1'b1);
      wait_flag(tws_pkg::SC_DAT_ACK);
      load(1'b0);
      mread(1'b1);
      wait_flag(tws_pkg::SC_LST_ACK);
      xfer(1'b1, tws_pkg::OFS_CTRL, ctl(1'b1, 1'b0), r);
      xfer(1'b0, tws_pkg::OFS_STAT, 32'h0, r);
      chk("cleared status", 32'hfb, r);
      pm_u.get_byte(1'b1, v);
      chk("ones", 32'hff, {24'h0, v});
      pm_u.stop_cond();
      // Nack ends the read; leave with start request and no ack
      addr_rd(7'h35, 1'b1);
      wait_flag(tws_pkg::SC_OWN_RD);
      load(1'b1);
      mread(1'b0);
      wait_flag(tws_pkg::SC_DAT_NAK);
      xfer(1'b1, tws_pkg::OFS_CTRL, ctl(1'b0, 1'b1), r);
      pm_u.stop_cond();
      repeat (50) @(posedge hclk);
      chk("start go", 32'h1, {31'h0, go_seen});
      addr_rd(7'h35, 1'b0);
      pm_u.stop_cond();
      // Recognition back with ack enable; lost arbitration code
      xfer(1'b1, tws_pkg::OFS_CTRL, 32'h44, r);
      @(posedge hclk) arb_lost <= 1'b1;
      addr_rd(7'h35, 1'b1);
      wait_flag(tws_pkg::SC_ARB_RD);
      @(posedge hclk) arb_lost <= 1'b0;
      load(1'b0);
      mread(1'b0);
      wait_flag(tws_pkg::SC_DAT_NAK);
      xfer(1'b1, tws_pkg::OFS_CTRL, ctl(1'b1, 1'b0), r);
      pm_u.stop_cond();
      // General call off, then on
      addr_rd(7'h00, 1'b0);
      pm_u.stop_cond();
      xfer(1'b1, tws_pkg::OFS_ADDR, 32'h6b, r);
      addr_rd(7'h00, 1'b1);
      wait_flag(tws_pkg::SC_OWN_RD);
      load(1'b0);
      mread(1'b0);
      wait_flag(tws_pkg::SC_DAT_NAK);
      xfer(1'b1, tws_pkg::OFS_CTRL, ctl(1'b1, 1'b0), r);
      pm_u.stop_cond();
      // Address match in deep sleep: wake, clock held until cleared
      @(posedge hclk) deep_sleep <= 1'b1;
      addr_rd(7'h35, 1'b1);
      wait_flag(tws_pkg::SC_OWN_RD);
      @(negedge hclk);
      chk("wake", 32'h1, {31'h0, wake_req});
      chk("scl held", 32'h1, {31'h0, scl_oe});
      load(1'b0);
      repeat (5) @(negedge hclk);
      chk("scl free", 32'h0, {31'h0, scl_oe});
      chk("wake done", 32'h0, {31'h0, wake_req});
      mread(1'b0);
      wait_flag(tws_pkg::SC_DAT_NAK);
      xfer(1'b1, tws_pkg::OFS_CTRL, ctl(1'b1, 1'b0), r);
      pm_u.stop_cond();
      @(posedge hclk) deep_sleep <= 1'b0;
      summarize();
   end
endmodule
